// file: include/bemf_pkg.sv
// Purpose: constants and types of the demag / zero-cross event logic
// Assumes: 200 MHz ref_clk, 8-bit register port, 8-bit timer
// Notes:   window codes are in microseconds as for a 4 MHz periph clock
//
// Contract
// - sensorless: Z blanking window after each D, 4-bit code, default longest
// - Z window opens after hardware D and after simulated D alike
// - codes 0-7 give 5-40 us, codes 8-15 give 60-200 us
// - after Z window, Z needs filter code plus one matching samples
// - sample count applies to hardware Z only; simulated Z fires at once
// - Z sample count also works in position-sensor mode
// - D and Z sampling runs at a software-selected rate
// - edge-relation and polarity bits pick D and Z levels; 0 means opposite
// - hardware D after programmed run of matching samples on phase input
// - capture enable copies commutation timer into demag time on each D
// - simulation enable fires D when timer equals demag time
// - both enabled: first D source to fire wins for the step
// - any D sets demag flag; interrupt request when its mask is set
// - at C, demag time not above timer fires simulated D, stores timer
// - sensorless: D blanked for programmable window after each commutation
// - any Z sets zero-cross flag; interrupt request when masked in
package bemf_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int TMR_W  = 8;
  localparam int WIN_W  = 8;
  localparam int RUN_W  = 5;
  localparam int SMP_W  = 14;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 5;
  localparam int US_TIME_NS       = 1000;
  localparam int US_CYCLES        = (US_TIME_NS + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
  localparam int PERIPH_PERIOD_NS = 250;
  localparam int SAMPLE_BASE_CYC  = PERIPH_PERIOD_NS / CLK_PERIOD_NS;
  localparam int WIN_LO_STEP_US   = 5;
  localparam int WIN_HI_BASE_US   = 60;
  localparam int WIN_HI_STEP_US   = 20;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_CONTROL_B   = 4'h0;
  localparam logic [3:0] OFS_POLARITY    = 4'h1;
  localparam logic [3:0] OFS_DEMAG_FILT  = 4'h2;
  localparam logic [3:0] OFS_ZERO_FILT   = 4'h3;
  localparam logic [3:0] OFS_DEMAG_TIME  = 4'h4;
  localparam logic [3:0] OFS_IRQ_STATUS  = 4'h5;
  localparam logic [3:0] OFS_IRQ_MASK    = 4'h6;
  localparam logic [3:0] OFS_STEP_STATUS = 4'h7;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_HW_DEMAG   = 0;
  localparam int BIT_SIM_DEMAG  = 1;
  localparam int BIT_EDGE_POL   = 2;
  localparam int BIT_HALL_SEL   = 3;
  localparam int BIT_RATE_LO    = 4;
  localparam int BIT_EDGE_REL   = 0;
  localparam int BIT_DEMAG_FLAG = 0;
  localparam int BIT_ZERO_FLAG  = 1;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CONTROL_B = 8'h00;
  localparam logic [7:0] RST_POLARITY  = 8'h00;
  localparam logic [7:0] RST_FILTER    = 8'hF0;
  localparam logic [7:0] RST_ZERO      = 8'h00;
  // ----------------------------------------------------------------
  // step sequence
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_DEMAG = 4'b0010,
    ST_ZERO  = 4'b0100,
    ST_DONE  = 4'b1000
  } step_t;

  // code to window length in microseconds
  function automatic logic [WIN_W-1:0] window_us(input logic [3:0] code);
    int idx;
    idx = int'(code[2:0]);
    if (code[3]) begin
      window_us = WIN_W'(WIN_HI_BASE_US + WIN_HI_STEP_US * idx);
    end else begin
      window_us = WIN_W'(WIN_LO_STEP_US * (idx + 1));
    end
  endfunction
endpackage

// file: src/event_filter.sv
// Purpose: blanking window followed by a consecutive-sample counter
// Assumes: us_tick and sample are one-cycle strobes on ref_clk
// Notes:   the window counts one tick more than asked so it is never short
module event_filter (
  // clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        reset,
  // control
  input  wire logic                        restart,
  input  wire logic                        enable,
  input  wire logic                        skip_window,
  input  wire logic [bemf_pkg::WIN_W-1:0]  blank_us,
  input  wire logic [3:0]                  limit_code,
  // time base and samples
  input  wire logic                        us_tick,
  input  wire logic                        sample,
  input  wire logic                        match,
  // result
  output logic                             hit,
  output logic                             blanking
);
  import bemf_pkg::*;

  typedef struct packed {
    logic [WIN_W-1:0] win;
    logic             open;
    logic [RUN_W-1:0] run;
  } filt_t;

  filt_t cur;
  filt_t next_cur;

  always_comb begin
    next_cur = cur;
    hit      = 1'b0;
    if (restart) begin
      next_cur.win  = '0;
      next_cur.open = skip_window;
      next_cur.run  = '0;
    end else if (enable) begin
      if (!cur.open) begin
        if (us_tick) begin
          if (cur.win == blank_us) begin
            next_cur.open = 1'b1;
          end else begin
            next_cur.win = WIN_W'(cur.win + 1'b1);
          end
        end
      end else if (sample) begin
        if (!match) begin
          next_cur.run = '0;
        end else if (cur.run == {1'b0, limit_code}) begin
          hit          = 1'b1;
          next_cur.run = '0;
        end else begin
          next_cur.run = RUN_W'(cur.run + 1'b1);
        end
      end
    end
  end

  assign blanking = enable && !cur.open;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end
endmodule

// file: src/bemf_event_logic.sv
// Purpose: demagnetization and zero-crossing event logic of one step
// Assumes: commutation_event and commutation_timer come from ref_clk logic
// Notes:   phase input is asynchronous and passes a three-stage sync
//
// The address map and strobed register access were left to the implementer.
module bemf_event_logic (
  // clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         reset,
  // register port
  input  wire logic [bemf_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [bemf_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                         reg_write,
  input  wire logic                         reg_read,
  output logic      [bemf_pkg::DATA_W-1:0]  reg_rdata,
  // motor side
  input  wire logic                         phase_sense_input,
  input  wire logic                         commutation_event,
  input  wire logic [bemf_pkg::TMR_W-1:0]   commutation_timer,
  input  wire logic                         zero_cross_sim_event,
  // events and requests
  output logic                              demag_event,
  output logic                              zero_cross_event,
  output logic                              demag_irq,
  output logic                              zero_cross_irq
);
  import bemf_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]        sync;
    logic              level;
    logic [SMP_W-1:0]  smp_cnt;
    logic              sample;
    logic [7:0]        us_cnt;
    logic              us_tick;
    step_t             step;
    logic [7:0]        control_reg_b;
    logic [7:0]        polarity_control_reg;
    logic [7:0]        demag_filter_reg;
    logic [7:0]        zero_cross_filter_reg;
    logic [TMR_W-1:0]  demag_time_reg;
    logic [7:0]        motor_irq_status_reg;
    logic [7:0]        motor_irq_mask_reg;
    logic [7:0]        rdata;
    logic              d_ev;
    logic              z_ev;
  } core_t;

  core_t s;
  core_t next_s;

  // ----------------------------------------------------------------
  // decoded controls
  // ----------------------------------------------------------------
  logic             hw_demag_capture_enable;
  logic             sim_demag_enable;
  logic             comparator_edge_polarity;
  logic             hall_sensor_select;
  logic             edge_relation_select;
  logic [2:0]       rate_sel;
  logic             z_level;
  logic             d_level;
  logic             hw_d_source;
  logic [SMP_W-1:0] smp_last;
  logic             d_at_commutation;
  logic             d_hit;
  logic             z_hit;
  logic             d_hw;
  logic             d_sim;
  logic             d_fire;
  logic             z_fire;
  logic             z_restart;
  logic             d_enable;
  logic             z_enable;
  logic             d_blank;
  logic             z_blank;
  logic [WIN_W-1:0] d_blank_us;
  logic [WIN_W-1:0] z_blank_us;

  always_comb begin
    hw_demag_capture_enable  = s.control_reg_b[BIT_HW_DEMAG];
    sim_demag_enable         = s.control_reg_b[BIT_SIM_DEMAG];
    comparator_edge_polarity = s.control_reg_b[BIT_EDGE_POL];
    hall_sensor_select       = s.control_reg_b[BIT_HALL_SEL];
    rate_sel                 = s.control_reg_b[BIT_RATE_LO +: 3];
    edge_relation_select     = s.polarity_control_reg[BIT_EDGE_REL];
    // Z expects the polarity level; D the opposite unless related
    z_level = comparator_edge_polarity;
    d_level = edge_relation_select ? comparator_edge_polarity
                                   : !comparator_edge_polarity;
    // hardware D is watched unless simulation alone is chosen
    hw_d_source = hw_demag_capture_enable || !sim_demag_enable;
    smp_last = SMP_W'((SAMPLE_BASE_CYC << rate_sel) - 1);
    d_blank_us = window_us(s.demag_filter_reg[7:4]);
    z_blank_us = window_us(s.zero_cross_filter_reg[7:4]);
  end

  // ----------------------------------------------------------------
  // event decisions
  // ----------------------------------------------------------------
  always_comb begin
    // stored time already passed at C: simulated D fires at once
    d_at_commutation = commutation_event && sim_demag_enable
                       && !hall_sensor_select
                       && (s.demag_time_reg <= commutation_timer);
    d_enable = (s.step == ST_DEMAG) && hw_d_source;
    z_enable = (s.step == ST_ZERO);
    d_hw  = d_enable && d_hit;
    d_sim = (s.step == ST_DEMAG) && sim_demag_enable
            && (commutation_timer == s.demag_time_reg);
    // the first source ends the demag phase; a later one is ignored
    d_fire = commutation_event ? d_at_commutation : (d_hw || d_sim);
    // simulated Z skips the sample count
    z_fire = !commutation_event && z_enable
             && (z_hit || zero_cross_sim_event);
    // a D of either kind opens the Z window
    z_restart = commutation_event || d_fire;
  end

  // ----------------------------------------------------------------
  // filters
  // ----------------------------------------------------------------
  // D blanking after each commutation
  event_filter u_demag_filter (
    .ref_clk     (ref_clk),
    .reset       (reset),
    .restart     (commutation_event),
    .enable      (d_enable),
    .skip_window (1'b0),
    .blank_us    (d_blank_us),
    .limit_code  (s.demag_filter_reg[3:0]),
    .us_tick     (s.us_tick),
    .sample      (s.sample),
    .match       (s.level == d_level),
    .hit         (d_hit),
    .blanking    (d_blank)
  );

  // sensor mode has no Z window but keeps the sample count
  event_filter u_zero_filter (
    .ref_clk     (ref_clk),
    .reset       (reset),
    .restart     (z_restart),
    .enable      (z_enable),
    .skip_window (hall_sensor_select),
    .blank_us    (z_blank_us),
    .limit_code  (s.zero_cross_filter_reg[3:0]),
    .us_tick     (s.us_tick),
    .sample      (s.sample),
    .match       (s.level == z_level),
    .hit         (z_hit),
    .blanking    (z_blank)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    // phase input: a change counts once stages two and three agree
    next_s.sync = {s.sync[1:0], phase_sense_input};
    if (s.sync[1] == s.sync[2]) begin
      next_s.level = s.sync[2];
    end
    // sampling strobe at the selected rate
    next_s.sample = 1'b0;
    if (s.smp_cnt >= smp_last) begin
      next_s.smp_cnt = '0;
      next_s.sample  = 1'b1;
    end else begin
      next_s.smp_cnt = SMP_W'(s.smp_cnt + 1'b1);
    end
    // microsecond tick for the windows
    next_s.us_tick = 1'b0;
    if (s.us_cnt == 8'(US_CYCLES - 1)) begin
      next_s.us_cnt  = '0;
      next_s.us_tick = 1'b1;
    end else begin
      next_s.us_cnt = 8'(s.us_cnt + 1'b1);
    end

    // step sequence
    case (s.step)
      ST_IDLE: begin
        next_s.step = ST_IDLE;
      end
      ST_DEMAG: begin
        if (d_fire) begin
          next_s.step = ST_ZERO;
        end
      end
      ST_ZERO: begin
        if (z_fire) begin
          next_s.step = ST_DONE;
        end
      end
      ST_DONE: begin
        next_s.step = ST_DONE;
      end
      default: begin
        next_s.step = ST_IDLE;
      end
    endcase
    // commutation starts the step afresh
    if (commutation_event) begin
      if (hall_sensor_select || d_at_commutation) begin
        next_s.step = ST_ZERO;
      end else begin
        next_s.step = ST_DEMAG;
      end
    end

    // register writes
    if (reg_write) begin
      case (reg_addr)
        OFS_CONTROL_B: begin
          next_s.control_reg_b = {1'b0, reg_wdata[6:0]};
        end
        OFS_POLARITY: begin
          next_s.polarity_control_reg = {7'h00, reg_wdata[0]};
        end
        OFS_DEMAG_FILT: begin
          next_s.demag_filter_reg = reg_wdata;
        end
        OFS_ZERO_FILT: begin
          next_s.zero_cross_filter_reg = reg_wdata;
        end
        OFS_DEMAG_TIME: begin
          next_s.demag_time_reg = reg_wdata;
        end
        OFS_IRQ_STATUS: begin
          // writing 0 clears a flag, writing 1 leaves it
          next_s.motor_irq_status_reg = s.motor_irq_status_reg & reg_wdata;
        end
        OFS_IRQ_MASK: begin
          next_s.motor_irq_mask_reg = {6'h00, reg_wdata[1:0]};
        end
        default: begin
          next_s.rdata = s.rdata;
        end
      endcase
    end

    // hardware use of demag time overrides a software write
    if (d_hw && hw_demag_capture_enable && !commutation_event) begin
      next_s.demag_time_reg = commutation_timer;
    end
    if (d_at_commutation) begin
      next_s.demag_time_reg = commutation_timer;
    end

    // flags: a set in the clearing cycle wins
    if (d_fire) begin
      next_s.motor_irq_status_reg[BIT_DEMAG_FLAG] = 1'b1;
    end
    if (z_fire) begin
      next_s.motor_irq_status_reg[BIT_ZERO_FLAG] = 1'b1;
    end
    next_s.d_ev = d_fire;
    next_s.z_ev = z_fire;

    // read data stand only in the cycle after the strobe
    next_s.rdata = 8'h00;
    if (reg_read) begin
      case (reg_addr)
        OFS_CONTROL_B: begin
          next_s.rdata = s.control_reg_b;
        end
        OFS_POLARITY: begin
          next_s.rdata = s.polarity_control_reg;
        end
        OFS_DEMAG_FILT: begin
          next_s.rdata = s.demag_filter_reg;
        end
        OFS_ZERO_FILT: begin
          next_s.rdata = s.zero_cross_filter_reg;
        end
        OFS_DEMAG_TIME: begin
          next_s.rdata = s.demag_time_reg;
        end
        OFS_IRQ_STATUS: begin
          next_s.rdata = s.motor_irq_status_reg;
        end
        OFS_IRQ_MASK: begin
          next_s.rdata = s.motor_irq_mask_reg;
        end
        OFS_STEP_STATUS: begin
          next_s.rdata = {s.level, z_blank, d_blank, 1'b0, s.step};
        end
        default: begin
          next_s.rdata = 8'h00;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s                       <= '0;
      s.step                  <= ST_IDLE;
      s.control_reg_b         <= RST_CONTROL_B;
      s.polarity_control_reg  <= RST_POLARITY;
      s.demag_filter_reg      <= RST_FILTER;
      s.zero_cross_filter_reg <= RST_FILTER;
      s.demag_time_reg        <= RST_ZERO;
      s.motor_irq_status_reg  <= RST_ZERO;
      s.motor_irq_mask_reg    <= RST_ZERO;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata        = s.rdata;
  assign demag_event      = s.d_ev;
  assign zero_cross_event = s.z_ev;
  // requests follow flag and mask, both from flops
  assign demag_irq = s.motor_irq_status_reg[BIT_DEMAG_FLAG]
                     && s.motor_irq_mask_reg[BIT_DEMAG_FLAG];
  assign zero_cross_irq = s.motor_irq_status_reg[BIT_ZERO_FLAG]
                          && s.motor_irq_mask_reg[BIT_ZERO_FLAG];
endmodule

// file: tb/bemf_event_checker_assertions.sv
// Purpose: port-level checks of the demag / zero-cross event logic
// Assumes: one ref_clk domain, synchronous active-high reset
// Notes:   the bench keeps simulated Z well clear of the D event
module bemf_event_checker (
  // clock and reset
  input wire logic                        ref_clk,
  input wire logic                        reset,
  // register port
  input wire logic                        reg_write,
  input wire logic                        reg_read,
  input wire logic [bemf_pkg::DATA_W-1:0] reg_rdata,
  // events and requests
  input wire logic                        demag_event,
  input wire logic                        zero_cross_event,
  input wire logic                        demag_irq,
  input wire logic                        zero_cross_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  import bemf_pkg::*;
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_demag_single: assert property (demag_event |=> !demag_event [*8])
    else $error("second demag pulse in one step");
  a_zero_single: assert property (zero_cross_event
    |=> !zero_cross_event [*8])
    else $error("second zero-cross pulse in one step");
  a_zero_blanked: assert property (demag_event
    |-> !zero_cross_event [*8])
    else $error("zero cross inside its blanking window");
  a_rdata_idle: assert property (!reg_read |=> reg_rdata == 8'h00)
    else $error("read data outside its read cycle");
  a_demag_irq_set: assert property ($rose(demag_irq)
    && !$past(reg_write) && !$past(reg_write, 2)
    |-> ##[0:1] ($past(demag_event) || demag_event))
    else $error("demag request without demag event");
  a_demag_irq_clr: assert property ($fell(demag_irq)
    |-> $past(reg_write) || $past(reg_write, 2))
    else $error("demag request dropped without a write");
  a_zero_irq_set: assert property ($rose(zero_cross_irq)
    && !$past(reg_write) && !$past(reg_write, 2)
    |-> ##[0:1] ($past(zero_cross_event) || zero_cross_event))
    else $error("zero-cross request without zero-cross event");
  a_zero_irq_clr: assert property ($fell(zero_cross_irq)
    |-> $past(reg_write) || $past(reg_write, 2))
    else $error("zero-cross request dropped without a write");
endmodule

bind bemf_event_logic bemf_event_checker i_chk (
  .ref_clk          (ref_clk),
  .reset            (reset),
  .reg_write        (reg_write),
  .reg_read         (reg_read),
  .reg_rdata        (reg_rdata),
  .demag_event      (demag_event),
  .zero_cross_event (zero_cross_event),
  .demag_irq        (demag_irq),
  .zero_cross_irq   (zero_cross_irq)
);

// file: tb/phase_model.sv
// Purpose: behavioural phase comparator facing the event logic
// Assumes: one step profile restarted by each commutation pulse
// Notes:   shows the rail level, then the D level, then the Z level
module phase_model (
  // clock and step start
  input  wire logic        ref_clk,
  input  wire logic        step_start,
  // step profile
  input  wire logic        d_level,
  input  wire logic        z_level,
  input  wire logic [15:0] demag_cyc,
  input  wire logic [15:0] zc_cyc,
  // comparator output
  output logic             phase
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] age = 16'h0000;
  always @(posedge ref_clk) begin
    if (step_start) begin
      age <= 16'h0000;
    end else if (age != 16'hFFFF) begin
      age <= age + 16'h0001;
    end
  end
  // the real demag edge comes demag_cyc cycles after step start, whatever any simulated D does
  always_comb begin
    if (age < demag_cyc) begin
      phase = ~d_level;
    end else if (age < zc_cyc) begin
      phase = d_level;
    end else begin
      phase = z_level;
    end
  end
endmodule

// file: tb/bemf_event_logic_test.sv
// Purpose: self-checking bench of the demag / zero-cross event logic
// Assumes: timer advances one count per ref_clk cycle
// Notes:   short window codes keep the run brief
module bemf_event_logic_test;
  timeunit 1ns;
  timeprecision 100ps;
  import bemf_pkg::*;
  logic              ref_clk = 1'b0;
  logic              reset = 1'b1;
  logic [ADDR_W-1:0] reg_addr = 4'h0;
  logic [DATA_W-1:0] reg_wdata = 8'h00;
  logic              reg_write = 1'b0;
  logic              reg_read = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic              commutation_event = 1'b0;
  logic [TMR_W-1:0]  commutation_timer = 8'h00;
  logic              zero_cross_sim_event = 1'b0;
  logic              demag_event, zero_cross_event, demag_irq, zero_cross_irq;
  logic              phase, d_lvl = 1'b1, z_lvl = 1'b0;
  logic [15:0]       demag_cyc = 16'h0000, zc_cyc = 16'hFFFF;
  int                failures = 0, cmp_count = 0;
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) commutation_timer <= commutation_timer + 8'h01;
  bemf_event_logic i_dut (.ref_clk(ref_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata),
    .phase_sense_input(phase), .commutation_event(commutation_event),
    .commutation_timer(commutation_timer),
    .zero_cross_sim_event(zero_cross_sim_event), .demag_event(demag_event),
    .zero_cross_event(zero_cross_event), .demag_irq(demag_irq),
    .zero_cross_irq(zero_cross_irq));
  phase_model i_phase (.ref_clk(ref_clk), .step_start(commutation_event),
    .d_level(d_lvl), .z_level(z_lvl), .demag_cyc(demag_cyc),
    .zc_cyc(zc_cyc), .phase(phase));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic end_sim();
    if (failures == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk(v, e);
  endtask
  task automatic in_range(input int n, input int lo, input int hi);
    chk({7'h00, n >= lo && n <= hi}, 8'h01);
  endtask
  // waits for a D (z=0) or Z (z=1) pulse; bound exhausted ends the run
  task automatic wait_ev(input bit z, input int lim, output int n);
    n = 0;
    while ((z ? zero_cross_event : demag_event) !== 1'b1) begin
      @(posedge ref_clk);
      #1 n++;
      if (n > lim) begin
        failures++;
        end_sim();
      end
    end
  endtask
  task automatic commutate(output logic [7:0] tc);
    @(posedge ref_clk);
    commutation_event <= 1'b1;
    @(posedge ref_clk);
    tc = commutation_timer;
    commutation_event <= 1'b0;
    #1;
  endtask
  task automatic do_reset();
    reset <= 1'b1;
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_values();
    rdc(OFS_DEMAG_FILT, RST_FILTER);
    rdc(OFS_ZERO_FILT, RST_FILTER);
    rdc(OFS_POLARITY, RST_POLARITY);
    rdc(OFS_DEMAG_TIME, 8'h00);
    wr(4'h9, 8'h5A);
    rdc(4'h9, 8'h00);
    wr(OFS_POLARITY, 8'hFF);
    rdc(OFS_POLARITY, 8'h01);
  endtask
  // hardware D and Z for one edge setting, sample rate and Z window
  task automatic t_hw_step(input logic rel, input logic pol,
                           input logic [3:0] zw, input logic r);
    logic [7:0] tc, v;
    int nd, nz, w, sp;
    realtime td;
    sp = r ? 100 : 50;
    w = zw[3] ? 60 + 20 * zw[2:0] : 5 * (zw[2:0] + 1);
    wr(OFS_POLARITY, {7'h00, rel});
    wr(OFS_CONTROL_B, {3'h0, r, 1'b0, pol, 2'b01});
    wr(OFS_DEMAG_FILT, 8'h01);
    wr(OFS_ZERO_FILT, {zw, 4'h0});
    wr(OFS_IRQ_MASK, 8'h03);
    wr(OFS_IRQ_STATUS, 8'h00);
    z_lvl <= pol;
    d_lvl <= rel ? pol : ~pol;
    demag_cyc <= 16'd300;
    zc_cyc <= 16'd1500;
    commutate(tc);
    wait_ev(0, 3000, nd);
    td = $realtime;
    v = commutation_timer;
    in_range(nd, 1000, 1210 + 2 * sp);
    rd(OFS_DEMAG_TIME, tc);
    in_range(int'(v - tc), 1, 2);
    chk({6'h00, zero_cross_irq, demag_irq}, 8'h01);
    wait_ev(1, 20000, nz);
    nz = int'(($realtime - td) / 5.0);
    in_range(nz, w * 200, w * 200 + 210 + sp);
    rdc(OFS_IRQ_STATUS, 8'h03);
    chk({6'h00, zero_cross_irq, demag_irq}, 8'h03);
    wr(OFS_IRQ_STATUS, 8'h02);
    rdc(OFS_IRQ_STATUS, 8'h02);
    chk({6'h00, zero_cross_irq, demag_irq}, 8'h02);
  endtask
  task automatic t_sensor();
    logic [7:0] tc;
    int nz;
    wr(OFS_CONTROL_B, 8'h08);
    wr(OFS_ZERO_FILT, 8'h03);
    d_lvl <= 1'b1;
    z_lvl <= 1'b0;
    demag_cyc <= 16'd0;
    zc_cyc <= 16'd500;
    commutate(tc);
    wait_ev(1, 2000, nz);
    in_range(nz, 650, 720);
    rdc(OFS_STEP_STATUS, 8'h08);
  endtask
  task automatic t_sim_demag();
    logic [7:0] tc, t;
    int n;
    wr(OFS_CONTROL_B, 8'h02);
    wr(OFS_POLARITY, 8'h00);
    wr(OFS_DEMAG_FILT, 8'h00);
    wr(OFS_ZERO_FILT, 8'h0F);
    demag_cyc <= 16'd0;
    zc_cyc <= 16'hFFFF;
    // align the timer so the stored time cannot wrap below the C value
    repeat (8'h10 - commutation_timer) @(posedge ref_clk);
    t = commutation_timer + 8'd100;
    wr(OFS_DEMAG_TIME, t);
    commutate(tc);
    wait_ev(0, 300, n);
    in_range(int'(commutation_timer - t), 1, 2);
    repeat (1300) @(posedge ref_clk);
    zero_cross_sim_event <= 1'b1;
    @(posedge ref_clk);
    zero_cross_sim_event <= 1'b0;
    #1 wait_ev(1, 3, n);
    // stored time below the timer at C: D at once, timer kept
    wr(OFS_ZERO_FILT, 8'h00);
    zc_cyc <= 16'd0;
    wr(OFS_DEMAG_TIME, 8'h00);
    commutate(tc);
    wait_ev(0, 3, n);
    wait_ev(1, 2000, n);
    in_range(n, 998, 1270);
    rdc(OFS_DEMAG_TIME, tc);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    do_reset();
    t_reset_values();
    for (int i = 0; i < 4; i++) begin
      t_hw_step(i[1], i[0], (i == 3) ? 4'h8 : 4'h0, i[0]);
    end
    t_sensor();
    t_sim_demag();
    do_reset();
    rdc(OFS_ZERO_FILT, RST_FILTER);
    rdc(OFS_STEP_STATUS, 8'h01);
    end_sim();
  end
endmodule
